// ===== hw/dop_agu.sv
// one data addressing unit: four pointers, four steps, one wrap length
// assumes the control side never sets and accesses the same pointer at once
`timescale 1ns/100ps
`default_nettype none
module dop_agu (
	input wire logic    ref_clk,
	input wire logic    rst,
	dop_agu_if.unit     bus
);
	import dop_pkg::*;
	logic [15:0] addressPointer_r [4];
	logic [15:0] pointerStep_r [4];
	logic [15:0] wrapLength_r;
	logic [15:0] wrapMask;
	logic [15:0] curPtr;

	// smear the wrap length down to find the low part that wraps
	always_comb begin
		wrapMask = wrapLength_r;
		for (int i = 1; i < 16; i = i * 2)
			wrapMask = wrapMask | (wrapMask >> i);
	end

	// effective address, reversed for the bit-reverse access mode
	assign curPtr = addressPointer_r[bus.idx];
	always_comb begin
		bus.addr = curPtr; // see RL14
		if (bus.mode == DOP_M_REVSTEP)
			bus.addr = {<<{curPtr}}; // see RL14
	end

	// one update path per pointer entry; a set beats a post-modify
	for (genvar g = 0; g < 4; g++) begin : gEntry
		logic [15:0] lo;
		logic [16:0] sum;
		logic [16:0] wrapped;
		always_comb begin
			lo = addressPointer_r[g] & wrapMask;
			sum = {1'b0, lo} + {pointerStep_r[g][15], pointerStep_r[g]};
			wrapped = sum;
			if (sum[16])
				wrapped = sum + {1'b0, wrapLength_r} + 17'h0_0001; // see RL24
			else if (sum[15:0] > wrapLength_r)
				wrapped = sum - {1'b0, wrapLength_r} - 17'h0_0001; // see RL24
		end
		always_ff @(posedge ref_clk) begin
			if (rst) begin
				addressPointer_r[g] <= 16'h0000;
				pointerStep_r[g] <= 16'h0000;
			end else begin
				if (bus.setStep && bus.idx == g)
					pointerStep_r[g] <= bus.setData;
				if (bus.setPtr && bus.idx == g) begin
					addressPointer_r[g] <= bus.setData;
				end else if (bus.req && bus.idx == g) begin
					case (bus.mode) // see RL23
					DOP_M_INC: addressPointer_r[g] <= addressPointer_r[g] + 16'h0001;
					DOP_M_DEC: addressPointer_r[g] <= addressPointer_r[g] - 16'h0001;
					DOP_M_STEP, DOP_M_REVSTEP:
						addressPointer_r[g] <= addressPointer_r[g] + pointerStep_r[g];
					DOP_M_MOD: addressPointer_r[g] <= // see RL24
						(addressPointer_r[g] & ~wrapMask) | (wrapped[15:0] & wrapMask);
					default: addressPointer_r[g] <= addressPointer_r[g];
					endcase
				end
			end
		end
	end

	// wrap length of this unit
	always_ff @(posedge ref_clk) begin
		if (rst)
			wrapLength_r <= 16'h0000;
		else if (bus.setWrap)
			wrapLength_r <= bus.setData; // see RL13
	end

	a_ptr_inc: assert property (@(posedge ref_clk) disable iff (rst) // see RL23
		bus.req && !bus.setPtr && bus.mode == DOP_M_INC |=>
		addressPointer_r[$past(bus.idx)] == $past(curPtr) + 16'h0001)
		else $error("pointer increment wrong");
	a_ptr_hold: assert property (@(posedge ref_clk) disable iff (rst) // see RL23
		!bus.req && !bus.setPtr |=> $stable(addressPointer_r[0]))
		else $error("pointer moved without access");
endmodule
`default_nettype wire

// ===== hw/dop_agu_if.sv
// link between the datapath control and one data addressing unit
// assumes both ends run on the datapath clock
`timescale 1ns/100ps
`default_nettype none
interface dop_agu_if;
	import dop_pkg::*;
	logic           req;
	logic [1:0]     idx;
	dop_mod_t       mode;
	logic           setPtr;
	logic           setStep;
	logic           setWrap;
	logic [15:0]    setData;
	logic [15:0]    addr;
	modport ctl  (output req, idx, mode, setPtr, setStep, setWrap, setData,
		input addr);
	modport unit (input req, idx, mode, setPtr, setStep, setWrap, setData,
		output addr);
endinterface
`default_nettype wire

// ===== hw/dop_consts.svh
// offsets, field positions, reset values, address limits and shift counts of the datapath
// assumes inclusion by bare name from files that need these figures
`ifndef DOP_CONSTS_SVH
`define DOP_CONSTS_SVH
`define DOP_OFS_WAIT_DATA   4'h0
`define DOP_OFS_WAIT_INSTR  4'h1
`define DOP_OFS_STATUS      4'h2
`define DOP_OV_BIT          0
`define DOP_WAIT_DATA_RST   16'hFFFF
`define DOP_WAIT_INSTR_RST  16'h00FF
`define DOP_INT_RAM_TOP     16'h07FF
`define DOP_PERIPH_BASE     16'hFFC0
`define DOP_SHIFT_ONE       1
`define DOP_SHIFT_SIXTEEN   16
`define DOP_SHIFT_MAX       6'd40
`endif

// ===== hw/dop_datapath.sv
// operation unit and data addressing of a 16/40-bit fixed-point processor
// assumes a decoder on the same clock issues one operation per cycle
// Functional notes
// RL1: high half feeds signed multiply and load/store
// RL2: low half for unsigned, shift, transfers, loops
// RL3: guard byte is load/store register
// RL4: 16x16 product added or subtracted to 40
// RL5: signed-signed, signed-unsigned, unsigned-unsigned products
// RL6: accumulator input optionally shifted right 1/16
// RL7: ALU does arithmetic and logic on 40 bits
// RL8: shifter left/right, arithmetic or zero fill
// RL9: normalise count, 32-bit input, upper bits zero
// RL10: condition false suppresses the operation
// RL11: two addressing units, four pointers each
// RL12: pointers 0-3 X space, 4-7 Y space
// RL13: modulo uses X or Y wrap length
// RL14: indirect address from pointer, optionally reversed
// RL15: direct address taken from instruction field
// RL16: 64K instruction words, two 64K data spaces
// RL17: external access stretches cycle to two or more
// RL18: wait code selects 0,1,3,7 per region
// RL19: wait pin extends data accesses
// RL20: instructions are single 32-bit words
// RL21: each space has 64-word peripheral region
// RL22: eight 40-bit general registers
// RL23: post-modify only with access, six kinds
// RL24: modulo wraps low part, keeps high part
// RL25: overflow flag sticky until software clears
// RL26: products sign-extended to 40 before accumulating
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`include "dop_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module dop_datapath #(
	parameter int ADDR_W = 16, // see RL16
	parameter int INSTR_W = 32 // see RL20
) (
	input wire logic              ref_clk,
	input wire logic              rst,
	input wire logic              opValid,
	input wire dop_pkg::dop_op_t  opCode,
	input wire dop_pkg::dop_cond_t opCond,
	input wire logic [2:0]        opCondReg,
	input wire logic [2:0]        opDst,
	input wire logic [2:0]        opSrcA,
	input wire logic [2:0]        opSrcB,
	input wire logic [2:0]        opSrcC,
	input wire logic [39:0]       opImm,
	input wire logic              opUseImm,
	output logic                  opDone,
	input wire logic              ldValid,
	input wire logic [2:0]        ldReg,
	input wire dop_pkg::dop_part_t ldPart,
	input wire logic [15:0]       ldData,
	input wire logic              stValid,
	input wire logic [2:0]        stReg,
	input wire dop_pkg::dop_part_t stPart,
	output logic [15:0]           stData,
	input wire logic              memValid,
	input wire logic              memDirect,
	input wire logic              memDirectY,
	input wire logic [INSTR_W-1:0] memInstr,
	input wire logic [2:0]        memPtr,
	input wire dop_pkg::dop_mod_t memMode,
	output logic [ADDR_W-1:0]     memAddr,
	output logic                  memSpaceY,
	output logic                  memPeriph,
	input wire logic              aguSetValid,
	input wire logic [1:0]        aguSetKind,
	input wire logic [2:0]        aguSetIdx,
	input wire logic              aguSetFromReg,
	input wire logic [2:0]        aguSetReg,
	input wire logic [15:0]       aguSetImm,
	input wire logic              loopReq,
	input wire logic [2:0]        loopReg,
	output logic [15:0]           loopCount,
	input wire logic              accStart,
	input wire logic              accInstr,
	input wire logic              accSpaceY,
	input wire logic [ADDR_W-1:0] accAddr,
	input wire logic              waitPinN,
	output logic                  accBusy,
	input wire logic [3:0]        regAddr,
	input wire logic [15:0]       regWrData,
	input wire logic              regWr,
	input wire logic              regRd,
	output logic [15:0]           regRdData,
	output logic                  overflowFlag
);
	import dop_pkg::*;
	logic [39:0] genReg_r [8]; // see RL22
	logic [39:0] a, b, c, accIn, prod40, res;
	logic signed [16:0] mulA, mulB;
	logic signed [33:0] prod;
	logic [40:0] sum41;
	logic [5:0] shAmt;
	logic resOv, opWr, ovSet, ovClr, condTrue, opFire;
	logic [15:0] waitData_r, waitInstr_r;
	logic overflowFlag_r;
	dop_wstate_t wState_r;
	logic [3:0] wCount_r;
	logic [1:0] waitCode;
	logic [3:0] waitLen;
	logic w1_r, w2_r, w3_r, waitLvl_r, extAcc;
	logic [39:0] cj;

	// redundant sign bits below bit 31 give the normalising shift
	function automatic logic [4:0] normCnt(input logic [31:0] v);
		logic done;
		logic [4:0] n;
		n = 5'd0;
		done = 1'b0;
		for (int i = 30; i >= 0; i--) begin
			if (!done && v[i] == v[31])
				n = n + 5'd1;
			else
				done = 1'b1;
		end
		return n;
	endfunction

	// operations stall while an external access is being stretched
	assign opFire = opValid && !accBusy;
	assign a = genReg_r[opSrcA];
	assign b = opUseImm ? opImm : genReg_r[opSrcB];
	assign c = genReg_r[opSrcC];

	// condition judge on a full 40-bit register
	assign cj = genReg_r[opCondReg];
	always_comb begin
		case (opCond) // see RL10
		DOP_C_ALWAYS: condTrue = 1'b1;
		DOP_C_ZERO:   condTrue = (cj == 40'h00_0000_0000);
		DOP_C_NZ:     condTrue = (cj != 40'h00_0000_0000);
		DOP_C_NEG:    condTrue = cj[39];
		DOP_C_POS:    condTrue = !cj[39] && (cj != 40'h00_0000_0000);
		DOP_C_GE:     condTrue = !cj[39];
		DOP_C_LE:     condTrue = cj[39] || (cj == 40'h00_0000_0000);
		DOP_C_OV:     condTrue = overflowFlag_r;
		default:      condTrue = 1'b0;
		endcase
	end

	// multiplier operands: high half signed, low half unsigned
	always_comb begin
		mulA = {a[31], a[31:16]}; // see RL1
		mulB = {b[31], b[31:16]}; // see RL1
		if (opCode == DOP_MAC_SU)
			mulB = {1'b0, b[15:0]}; // see RL2, RL5
		if (opCode == DOP_MAC_UU) begin
			mulA = {1'b0, a[15:0]}; // see RL5
			mulB = {1'b0, b[15:0]}; // see RL5
		end
	end
	assign prod = mulA * mulB; // see RL4
	assign prod40 = {{6{prod[33]}}, prod}; // see RL26

	// accumulator input with optional arithmetic pre-shift
	always_comb begin
		case (opCode) // see RL6
		DOP_MAC_SH1:  accIn = $signed(c) >>> `DOP_SHIFT_ONE;
		DOP_MAC_SH16: accIn = $signed(c) >>> `DOP_SHIFT_SIXTEEN;
		DOP_MUL:      accIn = 40'h00_0000_0000;
		default:      accIn = c;
		endcase
	end

	// shift amount from the low half, saturated at the full width
	assign shAmt = (|b[15:6] || b[5:0] > `DOP_SHIFT_MAX) ? `DOP_SHIFT_MAX
		: b[5:0]; // see RL2

	// main result mux; the sum is one bit wider to see overflow
	always_comb begin
		sum41 = 41'h000_0000_0000;
		res = 40'h00_0000_0000;
		resOv = 1'b0;
		opWr = opFire && condTrue; // see RL10
		case (opCode)
		DOP_MAC_SS, DOP_MAC_SU, DOP_MAC_UU, DOP_MAC_SH1, DOP_MAC_SH16,
		DOP_MUL: sum41 = {accIn[39], accIn} + {prod40[39], prod40}; // see RL4
		DOP_MSUB: sum41 = {accIn[39], accIn} - {prod40[39], prod40}; // see RL4
		DOP_ADD: sum41 = {a[39], a} + {b[39], b}; // see RL7
		DOP_SUB: sum41 = {a[39], a} - {b[39], b}; // see RL7
		default: sum41 = 41'h000_0000_0000;
		endcase
		case (opCode)
		DOP_AND:  res = a & b; // see RL7
		DOP_OR:   res = a | b; // see RL7
		DOP_XOR:  res = a ^ b; // see RL7
		DOP_SRA:  res = $signed(a) >>> shAmt; // see RL8
		DOP_SRL:  res = a >> shAmt; // see RL8
		DOP_SLL:  res = a << shAmt; // see RL8
		DOP_NORM: res = {35'h0_0000_0000, normCnt(a[31:0])}; // see RL9
		default: begin
			res = sum41[39:0];
			resOv = sum41[40] ^ sum41[39];
		end
		endcase
	end
	assign ovSet = opWr && resOv;
	assign ovClr = regWr && regAddr == `DOP_OFS_STATUS && regWrData[`DOP_OV_BIT];

	// register file, one write path per entry; an operation beats a load
	for (genvar g = 0; g < 8; g++) begin : gReg
		always_ff @(posedge ref_clk) begin
			if (rst) begin
				genReg_r[g] <= 40'h00_0000_0000;
			end else if (opWr && opDst == g) begin
				genReg_r[g] <= res;
			end else if (ldValid && ldReg == g) begin
				case (ldPart)
				DOP_P_LOW:   genReg_r[g][15:0] <= ldData; // see RL2
				DOP_P_HIGH:  genReg_r[g][31:16] <= ldData; // see RL1
				DOP_P_GUARD: genReg_r[g][39:32] <= ldData[7:0]; // see RL3
				default: genReg_r[g] <= {{8{ldData[15]}}, ldData, 16'h0000};
				endcase
			end
		end
	end

	// store data and loop count are registered views of one part
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			stData <= 16'h0000;
			loopCount <= 16'h0000;
			opDone <= 1'b0;
		end else begin
			opDone <= opWr;
			if (stValid) begin
				case (stPart)
				DOP_P_LOW:   stData <= genReg_r[stReg][15:0]; // see RL2
				DOP_P_GUARD: stData <= {8'h00, genReg_r[stReg][39:32]}; // see RL3
				default:     stData <= genReg_r[stReg][31:16]; // see RL1
				endcase
			end
			if (loopReq)
				loopCount <= genReg_r[loopReg][15:0]; // see RL2
		end
	end

	// sticky overflow; a new overflow wins over a clear in the same cycle
	always_ff @(posedge ref_clk) begin
		if (rst)
			overflowFlag_r <= 1'b0;
		else if (ovSet)
			overflowFlag_r <= 1'b1; // see RL25
		else if (ovClr)
			overflowFlag_r <= 1'b0;
	end
	assign overflowFlag = overflowFlag_r;

	// two addressing units; pointer bit 2 picks X or Y
	dop_agu_if aguBus [2] ();
	for (genvar u = 0; u < 2; u++) begin : gUnit
		logic setHere;
		// a wrap set picks its unit by index bit 0, the rest by bit 2
		assign setHere = aguSetValid && (aguSetKind == 2'd3 ? aguSetIdx[0] == u
			: aguSetIdx[2] == u); // see RL13
		assign aguBus[u].req = memValid && !memDirect && memPtr[2] == u; // see RL12
		assign aguBus[u].idx = aguSetValid ? aguSetIdx[1:0] : memPtr[1:0];
		assign aguBus[u].mode = memMode;
		assign aguBus[u].setPtr = setHere && aguSetKind == 2'd0;
		assign aguBus[u].setStep = setHere && aguSetKind == 2'd1;
		assign aguBus[u].setWrap = setHere && aguSetKind == 2'd3;
		assign aguBus[u].setData = aguSetFromReg ? genReg_r[aguSetReg][15:0]
			: aguSetImm; // see RL2
		dop_agu uAgu (
			.ref_clk (ref_clk),
			.rst     (rst),
			.bus     (aguBus[u])
		); // see RL11
	end

	// address out, registered; direct mode takes the instruction field
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			memAddr <= '0;
			memSpaceY <= 1'b0;
			memPeriph <= 1'b0;
		end else if (memValid) begin
			if (memDirect) begin
				memAddr <= memInstr[ADDR_W-1:0]; // see RL15
				memSpaceY <= memDirectY;
				memPeriph <= memInstr[ADDR_W-1:0] >= `DOP_PERIPH_BASE; // see RL21
			end else begin
				memAddr <= memPtr[2] ? aguBus[1].addr : aguBus[0].addr; // see RL14
				memSpaceY <= memPtr[2]; // see RL12
				memPeriph <= (memPtr[2] ? aguBus[1].addr : aguBus[0].addr)
					>= `DOP_PERIPH_BASE; // see RL21
			end
		end
	end

	// wait pin: three stages, a change counts once stages two and three agree
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			w1_r <= 1'b1;
			w2_r <= 1'b1;
			w3_r <= 1'b1;
			waitLvl_r <= 1'b1;
		end else begin
			w1_r <= waitPinN;
			w2_r <= w1_r;
			w3_r <= w2_r;
			if (w2_r == w3_r)
				waitLvl_r <= w3_r;
		end
	end

	// region code: instructions by top two bits, data by space and top two
	assign extAcc = accAddr > `DOP_INT_RAM_TOP && accAddr < `DOP_PERIPH_BASE;
	assign waitCode = accInstr ? waitInstr_r[{accAddr[15:14], 1'b0} +: 2]
		: waitData_r[{accSpaceY, accAddr[15:14], 1'b0} +: 2]; // see RL18
	assign waitLen = {1'b0, waitCode[1] & waitCode[0], waitCode[1],
		|waitCode} + 4'd1; // see RL17, RL18

	// stretch engine; one base cycle plus coded waits, then the pin
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wState_r <= DOP_W_IDLE;
			wCount_r <= 4'd0;
		end else begin
			case (wState_r)
			DOP_W_IDLE: if (accStart && extAcc) begin
				wState_r <= DOP_W_COUNT; // see RL17
				wCount_r <= waitLen - 4'd1;
			end
			DOP_W_COUNT: if (wCount_r != 4'd0)
				wCount_r <= wCount_r - 4'd1;
			else if (!accInstr && !waitLvl_r)
				wState_r <= DOP_W_PIN; // see RL19
			else
				wState_r <= DOP_W_IDLE;
			DOP_W_PIN: if (waitLvl_r)
				wState_r <= DOP_W_IDLE; // see RL19
			default: wState_r <= DOP_W_IDLE;
			endcase
		end
	end
	assign accBusy = wState_r != DOP_W_IDLE;

	// wait settings and status
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			waitData_r <= `DOP_WAIT_DATA_RST;
			waitInstr_r <= `DOP_WAIT_INSTR_RST;
			regRdData <= 16'h0000;
		end else begin
			if (regWr && regAddr == `DOP_OFS_WAIT_DATA)
				waitData_r <= regWrData;
			if (regWr && regAddr == `DOP_OFS_WAIT_INSTR)
				waitInstr_r <= {8'h00, regWrData[7:0]};
			if (regRd) begin
				case (regAddr)
				`DOP_OFS_WAIT_DATA:  regRdData <= waitData_r;
				`DOP_OFS_WAIT_INSTR: regRdData <= waitInstr_r;
				`DOP_OFS_STATUS:     regRdData <= {14'h0000, accBusy, overflowFlag_r};
				default:             regRdData <= 16'h0000;
				endcase
			end
		end
	end

	a_ov_sticky: assert property (@(posedge ref_clk) disable iff (rst) // see RL25
		overflowFlag_r && !ovClr |=> overflowFlag_r)
		else $error("overflow flag lost");
	a_norm_upper: assert property (@(posedge ref_clk) disable iff (rst) // see RL9
		opWr && opCode == DOP_NORM |=> genReg_r[$past(opDst)][39:5] == 35'h0)
		else $error("normalise count upper bits set");
	a_cond_block: assert property (@(posedge ref_clk) disable iff (rst) // see RL10
		opFire && !condTrue && !ldValid |=>
		genReg_r[$past(opDst)] == $past(genReg_r[opDst]))
		else $error("suppressed operation wrote");
	a_load_high: assert property (@(posedge ref_clk) disable iff (rst) // see RL1
		ldValid && ldPart == DOP_P_HIGH && !(opWr && opDst == ldReg) |=>
		genReg_r[$past(ldReg)][31:16] == $past(ldData))
		else $error("high half load wrong");
	a_store_guard: assert property (@(posedge ref_clk) disable iff (rst) // see RL3
		stValid && stPart == DOP_P_GUARD |=>
		stData == {8'h00, $past(genReg_r[stReg][39:32])})
		else $error("guard byte store wrong");
	a_instr_stretch: assert property (@(posedge ref_clk) disable iff (rst) // see RL17
		!accBusy && accStart && extAcc |=> accBusy)
		else $error("external access not stretched");
	a_pin_hold: assert property (@(posedge ref_clk) disable iff (rst) // see RL19
		wState_r == DOP_W_PIN && !waitLvl_r |=> accBusy)
		else $error("wait pin ignored");
	a_srl_fill: assert property (@(posedge ref_clk) disable iff (rst) // see RL8
		opWr && opCode == DOP_SRL && shAmt != 6'd0 |=>
		genReg_r[$past(opDst)][39] == 1'b0)
		else $error("logical shift filled ones");
endmodule
`default_nettype wire

// ===== hw/dop_pkg.sv
// types shared by the datapath and its addressing units
// assumes nothing beyond a SystemVerilog compiler
package dop_pkg;
	typedef enum logic [4:0] {
		DOP_MAC_SS, DOP_MAC_SU, DOP_MAC_UU, DOP_MSUB, DOP_MAC_SH1,
		DOP_MAC_SH16, DOP_MUL, DOP_ADD, DOP_SUB, DOP_AND, DOP_OR,
		DOP_XOR, DOP_SRA, DOP_SRL, DOP_SLL, DOP_NORM
	} dop_op_t;
	typedef enum logic [2:0] {
		DOP_C_ALWAYS, DOP_C_ZERO, DOP_C_NZ, DOP_C_NEG, DOP_C_POS,
		DOP_C_GE, DOP_C_LE, DOP_C_OV
	} dop_cond_t;
	typedef enum logic [2:0] {
		DOP_M_KEEP, DOP_M_INC, DOP_M_DEC, DOP_M_STEP, DOP_M_MOD,
		DOP_M_REVSTEP
	} dop_mod_t;
	typedef enum logic [1:0] {
		DOP_P_LOW, DOP_P_HIGH, DOP_P_GUARD, DOP_P_FULL
	} dop_part_t;
	typedef enum logic [1:0] {
		DOP_W_IDLE = 2'b00, DOP_W_COUNT = 2'b01, DOP_W_PIN = 2'b11
	} dop_wstate_t;
endpackage

// ===== verification/dop_ext_mem_model.sv
// far-side model: external memory that can hold the wait pin low
// assumes the bench raises stall before an access it wants stretched
`timescale 1ns/100ps
`default_nettype none
module dop_ext_mem_model #(
	parameter int HOLD = 6
) (
	input wire logic ref_clk,
	input wire logic accStart,
	input wire logic stall,
	output logic     waitPinN
);
	int cnt = 0;
	// pin is pulled up, so outside a stretch it reads high
	always @(posedge ref_clk) begin
		if (accStart && stall)
			cnt <= HOLD;
		else if (cnt != 0)
			cnt <= cnt - 1;
	end
	assign waitPinN = (cnt == 0);
endmodule
`default_nettype wire

// ===== verification/tb_dop_datapath.sv
// self-checking bench of the operation datapath and address units
// assumes the external memory model drives the wait pin
`timescale 1ns/100ps
`default_nettype none
module tb_dop_datapath;
	import dop_pkg::*;
	logic ref_clk = 0, rst = 1, opValid = 0, opUseImm = 0, ldValid = 0;
	logic stValid = 0, memValid = 0, memDirect = 0, memDirectY = 0;
	logic aguSetValid = 0, aguSetFromReg = 0, loopReq = 0, accStart = 0;
	logic accInstr = 0, accSpaceY = 0, regWr = 0, regRd = 0, stall = 0;
	dop_op_t opCode = DOP_ADD;
	dop_cond_t opCond = DOP_C_ALWAYS;
	dop_part_t ldPart = DOP_P_LOW, stPart = DOP_P_LOW;
	dop_mod_t memMode = DOP_M_KEEP;
	logic [2:0] opCondReg = 3'h4, opDst = 0, opSrcA = 0, opSrcB = 0;
	logic [2:0] opSrcC = 0, ldReg = 0, stReg = 0, memPtr = 0, aguSetIdx = 0;
	logic [2:0] aguSetReg = 0, loopReg = 0;
	logic [1:0] aguSetKind = 0;
	logic [3:0] regAddr = 0;
	logic [15:0] ldData = 0, aguSetImm = 0, regWrData = 0, accAddr = 0;
	logic [39:0] opImm = 40'h00_0000_0000;
	logic [31:0] memInstr = 32'h1234_FFC5;
	logic opDone, memSpaceY, memPeriph, accBusy, overflowFlag, waitPinN;
	logic [15:0] stData, memAddr, loopCount, regRdData;
	int failCount = 0, checkCount = 0;

	always #5 ref_clk = ~ref_clk;

	dop_datapath DUT (.ref_clk, .rst, .opValid, .opCode, .opCond,
		.opCondReg, .opDst, .opSrcA, .opSrcB, .opSrcC, .opImm, .opUseImm,
		.opDone, .ldValid, .ldReg, .ldPart, .ldData, .stValid, .stReg,
		.stPart, .stData, .memValid, .memDirect, .memDirectY, .memInstr,
		.memPtr, .memMode, .memAddr, .memSpaceY, .memPeriph, .aguSetValid,
		.aguSetKind, .aguSetIdx, .aguSetFromReg, .aguSetReg, .aguSetImm,
		.loopReq, .loopReg, .loopCount, .accStart, .accInstr, .accSpaceY,
		.accAddr, .waitPinN, .accBusy, .regAddr, .regWrData, .regWr, .regRd,
		.regRdData, .overflowFlag);
	dop_ext_mem_model MEM (.ref_clk, .accStart, .stall, .waitPinN);

	task automatic finishTest();
		$display("checks %0d mismatches %0d", checkCount, failCount);
		if (failCount == 0 && checkCount > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(string nm, logic [39:0] seen, logic [39:0] exp);
		checkCount++;
		if (seen !== exp) begin
			failCount++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// bus and strobe helpers: strobe one cycle, judge after it lands
	task automatic rd(logic [3:0] a, logic [15:0] e);
		@(posedge ref_clk) begin regRd <= 1; regAddr <= a; end
		@(posedge ref_clk) regRd <= 0;
		#1 chk("regRdData", regRdData, e);
	endtask
	task automatic wr(logic [3:0] a, logic [15:0] d);
		@(posedge ref_clk) begin regWr <= 1; regAddr <= a; regWrData <= d; end
		@(posedge ref_clk) regWr <= 0;
	endtask
	task automatic ld(logic [2:0] r, dop_part_t p, logic [15:0] d);
		@(posedge ref_clk) begin ldValid <= 1; ldReg <= r; ldPart <= p; ldData <= d; end
		@(posedge ref_clk) ldValid <= 0;
	endtask
	task automatic st(logic [2:0] r, dop_part_t p, logic [15:0] e);
		@(posedge ref_clk) begin stValid <= 1; stReg <= r; stPart <= p; end
		@(posedge ref_clk) stValid <= 0;
		#1 chk("stData", (p == DOP_P_GUARD) ? stData[7:0] : stData, e);
	endtask
	task automatic op(dop_op_t c, dop_cond_t k, logic [2:0] d, a, b, s, logic e);
		@(posedge ref_clk) begin
			opValid <= 1; opCode <= c; opCond <= k;
			opDst <= d; opSrcA <= a; opSrcB <= b; opSrcC <= s;
		end
		@(posedge ref_clk) opValid <= 0;
		#1 chk("opDone", opDone, e);
	endtask
	// one operation, then read one part of its result
	task automatic ops(dop_op_t c, logic [2:0] d, a, b, s, dop_part_t p, logic [15:0] e);
		op(c, DOP_C_ALWAYS, d, a, b, s, 1'b1);
		st(d, p, e);
	endtask
	task automatic aset(logic [1:0] k, logic [2:0] i, logic [15:0] v);
		@(posedge ref_clk) begin aguSetValid <= 1; aguSetKind <= k; aguSetIdx <= i; aguSetImm <= v; end
		@(posedge ref_clk) aguSetValid <= 0;
	endtask
	task automatic mem(logic dr, dy, logic [2:0] p, dop_mod_t m, logic [17:0] e);
		@(posedge ref_clk) begin
			memValid <= 1; memDirect <= dr; memDirectY <= dy; memPtr <= p; memMode <= m;
		end
		@(posedge ref_clk) memValid <= 0;
		#1 chk("memAddr", {memPeriph, memSpaceY, memAddr}, e);
	endtask
	// counts busy cycles of one access; a stuck busy ends the run
	task automatic acc(logic ins, logic [15:0] a, int e);
		int n;
		n = 0;
		@(posedge ref_clk) begin accStart <= 1; accInstr <= ins; accAddr <= a; end
		@(posedge ref_clk) accStart <= 0;
		#1;
		while (accBusy === 1'b1 && n < 60) begin
			n++;
			@(posedge ref_clk);
			#1;
		end
		if (n >= 60) begin
			failCount++;
			finishTest();
		end
		chk("busyCycles", n, e);
		repeat (8) @(posedge ref_clk);
	endtask

	task automatic tRegs();
		rd(4'h0, 16'hFFFF);
		rd(4'h1, 16'h00FF);
		rd(4'h2, 16'h0000);
		rd(4'hF, 16'h0000);
	endtask
	task automatic tMac();
		ld(3'h2, DOP_P_FULL, 16'hFFFF);
		ld(3'h3, DOP_P_FULL, 16'h0002);
		ld(3'h6, DOP_P_LOW, 16'hFFFF);
		ld(3'h7, DOP_P_LOW, 16'h0002);
		st(3'h2, DOP_P_GUARD, 16'h00FF);
		st(3'h3, DOP_P_HIGH, 16'h0002);
		ops(DOP_MAC_SS, 5, 2, 3, 4, DOP_P_LOW, 16'hFFFE);
		st(3'h5, DOP_P_GUARD, 16'h00FF);
		ops(DOP_MAC_SU, 1, 2, 7, 4, DOP_P_GUARD, 16'h00FF);
		ops(DOP_MAC_UU, 0, 6, 7, 4, DOP_P_HIGH, 16'h0001);
		ops(DOP_MSUB, 0, 2, 3, 0, DOP_P_HIGH, 16'h0002);
		ops(DOP_MAC_SH16, 0, 2, 3, 0, DOP_P_LOW, 16'h0000);
		ops(DOP_MAC_SH1, 1, 2, 3, 5, DOP_P_LOW, 16'hFFFD);
		ops(DOP_MUL, 0, 3, 3, 4, DOP_P_LOW, 16'h0004);
		ops(DOP_ADD, 0, 0, 0, 4, DOP_P_LOW, 16'h0008);
		ops(DOP_SUB, 0, 0, 3, 4, DOP_P_HIGH, 16'hFFFE);
		ops(DOP_XOR, 0, 0, 5, 4, DOP_P_LOW, 16'hFFF6);
		ops(DOP_AND, 0, 5, 7, 4, DOP_P_LOW, 16'h0002);
		ops(DOP_OR, 0, 7, 6, 4, DOP_P_LOW, 16'hFFFF);
		ops(DOP_SRA, 0, 5, 7, 4, DOP_P_GUARD, 16'h00FF);
		ops(DOP_SRL, 0, 5, 7, 4, DOP_P_GUARD, 16'h003F);
		ops(DOP_SLL, 0, 7, 7, 4, DOP_P_LOW, 16'h0008);
		ops(DOP_NORM, 0, 5, 5, 4, DOP_P_LOW, 16'h001E);
		st(3'h0, DOP_P_HIGH, 16'h0000);
		@(posedge ref_clk) begin loopReq <= 1; loopReg <= 3'h7; end
		@(posedge ref_clk) loopReq <= 0;
		#1 chk("loopCount", loopCount, 16'h0002);
	endtask
	// conditions and the sticky overflow flag
	task automatic tCond();
		op(DOP_ADD, DOP_C_NZ, 1, 7, 7, 4, 1'b0);
		st(3'h1, DOP_P_LOW, 16'hFFFD);
		op(DOP_ADD, DOP_C_ZERO, 1, 7, 7, 4, 1'b1);
		ld(3'h6, DOP_P_GUARD, 16'h007F);
		op(DOP_ADD, DOP_C_ALWAYS, 1, 6, 6, 4, 1'b1);
		#1 chk("overflowFlag", overflowFlag, 1'b1);
		op(DOP_ADD, DOP_C_ALWAYS, 1, 7, 7, 4, 1'b1);
		#1 chk("overflowFlag", overflowFlag, 1'b1);
		rd(4'h2, 16'h0001);
		op(DOP_SUB, DOP_C_OV, 1, 7, 7, 4, 1'b1);
		wr(4'h2, 16'h0001);
		rd(4'h2, 16'h0000);
		opUseImm <= 1;
		opImm <= 40'hFF_FFFF_FFFF;
		op(DOP_ADD, DOP_C_GE, 1, 7, 7, 4, 1'b1);
		st(3'h1, DOP_P_LOW, 16'h0001);
		op(DOP_ADD, DOP_C_NEG, 1, 7, 7, 4, 1'b0);
		op(DOP_ADD, DOP_C_POS, 1, 7, 7, 4, 1'b0);
		op(DOP_ADD, DOP_C_LE, 1, 7, 7, 4, 1'b1);
		opUseImm <= 0;
	endtask
	task automatic tAgu();
		aset(2'h0, 3'h0, 16'h0010);
		aset(2'h1, 3'h0, 16'h0003);
		mem(0, 0, 3'h0, DOP_M_INC, 18'h0_0010);
		mem(0, 0, 3'h0, DOP_M_STEP, 18'h0_0011);
		mem(0, 0, 3'h0, DOP_M_REVSTEP, 18'h0_2800);
		mem(0, 0, 3'h0, DOP_M_KEEP, 18'h0_0017);
		aset(2'h0, 3'h4, 16'h0020);
		mem(0, 0, 3'h4, DOP_M_DEC, 18'h1_0020);
		mem(0, 0, 3'h4, DOP_M_KEEP, 18'h1_001F);
		aset(2'h3, 3'h0, 16'h0003);
		aset(2'h3, 3'h1, 16'h0007);
		aset(2'h0, 3'h1, 16'h0102);
		aset(2'h1, 3'h1, 16'h0003);
		mem(0, 0, 3'h1, DOP_M_MOD, 18'h0_0102);
		mem(0, 0, 3'h1, DOP_M_KEEP, 18'h0_0101);
		aguSetFromReg <= 1;
		aset(2'h0, 3'h5, 16'h0000);
		aguSetFromReg <= 0;
		aset(2'h1, 3'h5, 16'h0005);
		mem(0, 0, 3'h5, DOP_M_MOD, 18'h1_001E);
		mem(0, 0, 3'h5, DOP_M_KEEP, 18'h1_001B);
		mem(1, 1, 3'h0, DOP_M_KEEP, 18'h3_FFC5);
		mem(1, 0, 3'h0, DOP_M_KEEP, 18'h2_FFC5);
	endtask
	// every wait code, a fetch, then the pin stretching a data access
	task automatic tWait();
		for (int c = 0; c < 4; c++) begin
			wr(4'h0, 16'(c));
			acc(1'b0, 16'h0800, 1 << c);
		end
		acc(1'b1, 16'h1000, 8);
		acc(1'b0, 16'h0010, 0);
		// seven coded waits give the synchronised pin time to be seen
		wr(4'h0, 16'h0003);
		stall <= 1;
		acc(1'b0, 16'h0800, 11);
		stall <= 0;
	endtask

	initial begin
		repeat (16) @(posedge ref_clk);
		rst <= 0;
		tRegs();
		tMac();
		tCond();
		tAgu();
		tWait();
		finishTest();
	end
endmodule
`default_nettype wire
